// *** src/pscb_pkg.sv ***
`default_nettype none
package pscb_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [8:0] OFS_OUTPUT_PIN = 9'h106;
    localparam logic [8:0] OFS_FAULT = 9'h107;
    localparam logic [8:0] OFS_CLK_POL = 9'h108;
    localparam logic [8:0] OFS_HOST_IRQ = 9'h109;
    localparam logic [8:0] OFS_AUTOSTART = 9'h10a;

    // ****************************************
    // Storable bits; the rest reads as zero
    // ****************************************
    localparam logic [7:0] MASK_OUTPUT_PIN = 8'h0c;
    localparam logic [7:0] MASK_FAULT = 8'h7f;
    localparam logic [7:0] MASK_CLK_POL = 8'hfc;
    localparam logic [7:0] MASK_HOST_IRQ = 8'hfe;
    localparam logic [7:0] MASK_AUTOSTART = 8'hff;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] RST_OUTPUT_PIN = 8'h00;
    localparam logic [7:0] RST_FAULT = 8'h00;
    localparam logic [7:0] RST_CLK_POL = 8'h00;
    localparam logic [7:0] RST_HOST_IRQ = 8'h00;
    localparam logic [7:0] RST_AUTOSTART = 8'h00;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int BIT_IRQ_POL = 3;
    localparam int BIT_DRIVE_STYLE = 2;
    localparam int HYST_LSB = 4;
    localparam int THR_LSB = 0;
    localparam int CLKINV_LSB = 3;
    localparam int BIT_DISCHARGE = 2;
    localparam int BIT_FB3_POL = 7;
    localparam int BIT_FB2_POL = 6;
    localparam int BIT_FORCE_RESET = 5;
    localparam int BIT_HS_CONT = 4;
    localparam int BIT_FAST_PLUS = 3;
    localparam int BIT_SYSEN_KEEP = 2;
    localparam int BIT_IRQ_DEFER = 1;
    localparam int CONV_AUTO_LSB = 0;
    localparam int SW_AUTO_LSB = 6;

    // ****************************************
    // Analog code scaling in millivolts
    // ****************************************
    localparam logic [8:0] HYST_BASE_MV = 9'h064;
    localparam logic [11:0] THR_BASE_MV = 12'h9c4;
    localparam logic [5:0] STEP_MV = 6'h32;
endpackage
`default_nettype wire

// *** src/pscb_config_bank.sv ***
// Notes on behaviour
// [RULE1] Interrupt and feedback-three polarity: 0 active low, 1 active high.
// [RULE2] Drive style bit: 0 push-pull, 1 drive low only, else release.
// [RULE3] Hysteresis code in 50 mV steps, 000 is 100 mV.
// [RULE4] Lower fault threshold code in 50 mV steps, 0000 is 2.50 V.
// [RULE5] Five bits invert converter clocks; core two opposite core one.
// [RULE6] Software should set processor polarity opposite to memory polarity.
// [RULE7] Discharge bit enables active discharge of converter rails.
// [RULE8] Feedback two polarity; power-good: low push-pull, high open-drain.
// [RULE9] Force bit holds the reset output asserted regardless of sequencing.
// [RULE10] Continuous high-speed bit keeps host interface in high-speed mode.
// [RULE11] Fast-plus bit selects fast-mode-plus timing on host interface.
// [RULE12] Keep bit stops second OTP read reloading system enable.
// [RULE13] Defer bit holds low-power interrupts until active mode is reached.
// [RULE14] Six converter autostart bits force converters on at power-up.
// [RULE15] Two switch autostart bits force load switches on at power-up.
// [RULE16] Written fields read back; reserved bits store nothing, read zero.
//
// Our own choice: the address-and-strobe port.
`default_nettype none
module pscb_config_bank #(
    parameter int ADDR_W = 9
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rd_data,
    input wire logic irq_pending,
    input wire logic in_active_mode,
    input wire logic seq_reset_request,
    input wire logic fb2_event,
    input wire logic fb2_is_power_good,
    input wire logic fb3_event,
    input wire logic otp_second_read,
    input wire logic otp_system_enable,
    input wire logic [5:0] conv_own_enable,
    input wire logic [1:0] switch_own_enable,
    output logic interrupt_request_output,
    output logic interrupt_request_oe,
    output logic reset_output_pin,
    output logic reset_output_oe,
    output logic feedback_two_out,
    output logic feedback_two_oe,
    output logic feedback_three_out,
    output logic [8:0] fault_hysteresis_mv,
    output logic [11:0] fault_threshold_mv,
    output logic [2:0] fault_hysteresis_code,
    output logic [3:0] fault_threshold_code,
    output logic [5:0] conv_clock_invert,
    output logic rail_discharge_enable,
    output logic continuous_highspeed_enable,
    output logic fast_plus_timing_enable,
    output logic system_enable,
    output logic [5:0] conv_powerup_enable,
    output logic [1:0] switch_powerup_enable
);
    // Narrower buses cannot reach the 0x10x offsets; refused at elaboration
    if (ADDR_W < 9) begin : g_addr_w_check
        $error("pscb_config_bank: ADDR_W must be at least 9");
    end

    // ****************************************
    // Register storage
    // ****************************************
    logic [7:0] output_pin_config;
    logic [7:0] supply_fault_threshold;
    logic [7:0] converter_clock_polarity;
    logic [7:0] host_interface_and_irq_config;
    logic [7:0] rail_powerup_auto_enable;

    // Upper address bits must be zero, so no alias above 0x1ff can hit
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [8:0] ofs);
        logic upper_zero;
        upper_zero = 1'b1;
        if (ADDR_W > 9) begin
            upper_zero = ((a >> 9) == '0);
        end
        hit = upper_zero && (a[8:0] == ofs);
    endfunction

    // One process per register, so a write never disturbs a neighbour.
    // Writes drop reserved bits, so the read path needs no second mask.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            output_pin_config <= pscb_pkg::RST_OUTPUT_PIN;
        end else if (wr_en && hit(addr, pscb_pkg::OFS_OUTPUT_PIN)) begin
            output_pin_config <= wr_data & pscb_pkg::MASK_OUTPUT_PIN; // RULE16
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            supply_fault_threshold <= pscb_pkg::RST_FAULT;
        end else if (wr_en && hit(addr, pscb_pkg::OFS_FAULT)) begin
            supply_fault_threshold <= wr_data & pscb_pkg::MASK_FAULT; // RULE16
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            converter_clock_polarity <= pscb_pkg::RST_CLK_POL;
        end else if (wr_en && hit(addr, pscb_pkg::OFS_CLK_POL)) begin
            converter_clock_polarity <= wr_data & pscb_pkg::MASK_CLK_POL;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            host_interface_and_irq_config <= pscb_pkg::RST_HOST_IRQ;
        end else if (wr_en && hit(addr, pscb_pkg::OFS_HOST_IRQ)) begin
            host_interface_and_irq_config <=
                wr_data & pscb_pkg::MASK_HOST_IRQ; // RULE16
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rail_powerup_auto_enable <= pscb_pkg::RST_AUTOSTART;
        end else if (wr_en && hit(addr, pscb_pkg::OFS_AUTOSTART)) begin
            rail_powerup_auto_enable <= wr_data & pscb_pkg::MASK_AUTOSTART;
        end
    end

    // ****************************************
    // Read port
    // ****************************************
    // Data stand for one cycle only; unmapped addresses answer zero
    logic [7:0] next_rd_data;

    always_comb begin
        next_rd_data = 8'h00;
        if (rd_en) begin
            if (hit(addr, pscb_pkg::OFS_OUTPUT_PIN)) begin
                next_rd_data = output_pin_config; // RULE16
            end else if (hit(addr, pscb_pkg::OFS_FAULT)) begin
                next_rd_data = supply_fault_threshold;
            end else if (hit(addr, pscb_pkg::OFS_CLK_POL)) begin
                next_rd_data = converter_clock_polarity;
            end else if (hit(addr, pscb_pkg::OFS_HOST_IRQ)) begin
                next_rd_data = host_interface_and_irq_config;
            end else if (hit(addr, pscb_pkg::OFS_AUTOSTART)) begin
                next_rd_data = rail_powerup_auto_enable;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= next_rd_data;
        end
    end

    // ****************************************
    // Field aliases
    // ****************************************
    logic irq_active_high;
    logic drive_low_only;
    logic fb3_active_high;
    logic fb2_active_high;
    logic force_reset;
    logic irq_defer;
    logic hs_cont;
    logic fast_plus;
    logic sysen_keep;

    assign irq_active_high = output_pin_config[pscb_pkg::BIT_IRQ_POL];
    assign drive_low_only = output_pin_config[pscb_pkg::BIT_DRIVE_STYLE];
    assign fb3_active_high =
        host_interface_and_irq_config[pscb_pkg::BIT_FB3_POL];
    assign fb2_active_high =
        host_interface_and_irq_config[pscb_pkg::BIT_FB2_POL];
    assign force_reset =
        host_interface_and_irq_config[pscb_pkg::BIT_FORCE_RESET];
    assign irq_defer = host_interface_and_irq_config[pscb_pkg::BIT_IRQ_DEFER];
    assign hs_cont = host_interface_and_irq_config[pscb_pkg::BIT_HS_CONT];
    assign fast_plus = host_interface_and_irq_config[pscb_pkg::BIT_FAST_PLUS];
    assign sysen_keep =
        host_interface_and_irq_config[pscb_pkg::BIT_SYSEN_KEEP];

    // ****************************************
    // Interrupt output
    // ****************************************
    // Gating by the mode level releases deferred requests as soon as the
    // device reaches active mode, without a separate pending store
    logic irq_asserted;
    logic irq_level;

    assign irq_asserted = irq_pending
        && (in_active_mode || !irq_defer); // RULE13
    assign irq_level = irq_active_high ? irq_asserted : !irq_asserted; // RULE1

    always_ff @(posedge clk) begin
        if (!rstn) begin
            interrupt_request_output <= 1'b1;
            interrupt_request_oe <= 1'b1;
        end else begin
            interrupt_request_output <= irq_level;
            // In drive-low style the external pull-up supplies the high level
            interrupt_request_oe <= !drive_low_only || !irq_level; // RULE2
        end
    end

    // ****************************************
    // Reset output, always active low
    // ****************************************
    // Sequencer and software force share one level; either holds it low.
    // The pin also stays low while this bank is in reset.
    logic rst_level;

    assign rst_level = !(seq_reset_request || force_reset); // RULE9

    always_ff @(posedge clk) begin
        if (!rstn) begin
            reset_output_pin <= 1'b0;
            reset_output_oe <= 1'b1;
        end else begin
            reset_output_pin <= rst_level;
            reset_output_oe <= !drive_low_only || !rst_level; // RULE2
        end
    end

    // ****************************************
    // Feedback outputs
    // ****************************************
    logic fb2_level;

    assign fb2_level = fb2_active_high ? fb2_event : !fb2_event; // RULE8

    always_ff @(posedge clk) begin
        if (!rstn) begin
            feedback_two_out <= 1'b1;
            feedback_two_oe <= 1'b1;
            feedback_three_out <= 1'b1;
        end else begin
            feedback_two_out <= fb2_level;
            // Open drain applies only in the power-good role
            feedback_two_oe <= !(fb2_is_power_good && fb2_active_high)
                || !fb2_level; // RULE8
            // Feedback three has no power-good role and is always driven
            feedback_three_out <= fb3_active_high ? fb3_event
                : !fb3_event; // RULE1
        end
    end

    // ****************************************
    // Supply fault comparator settings
    // ****************************************
    logic [2:0] hyst_code;
    logic [3:0] thr_code;

    assign hyst_code = supply_fault_threshold[pscb_pkg::HYST_LSB +: 3];
    assign thr_code = supply_fault_threshold[pscb_pkg::THR_LSB +: 4];

    always_ff @(posedge clk) begin
        if (!rstn) begin
            fault_hysteresis_code <= 3'h0;
            fault_threshold_code <= 4'h0;
            fault_hysteresis_mv <= pscb_pkg::HYST_BASE_MV;
            fault_threshold_mv <= pscb_pkg::THR_BASE_MV;
        end else begin
            fault_hysteresis_code <= hyst_code; // RULE3
            fault_threshold_code <= thr_code; // RULE4
            // Operands are widened before the product; the top codes still
            // fit, at 450 and 3250 millivolts
            fault_hysteresis_mv <= pscb_pkg::HYST_BASE_MV
                + 9'(hyst_code) * 9'(pscb_pkg::STEP_MV); // RULE3
            fault_threshold_mv <= pscb_pkg::THR_BASE_MV
                + 12'(thr_code) * 12'(pscb_pkg::STEP_MV); // RULE4
        end
    end

    // ****************************************
    // Converter clocks and discharge
    // ****************************************
    // Order: peri, io, memory, processor, core two, core one.
    // Processor versus memory polarity is left to software.
    // Core two is derived, never stored, so it cannot match core one.
    logic [4:0] clk_inv;

    assign clk_inv = converter_clock_polarity[pscb_pkg::CLKINV_LSB +: 5];

    always_ff @(posedge clk) begin
        if (!rstn) begin
            conv_clock_invert <= 6'h02;
            rail_discharge_enable <= 1'b0;
        end else begin
            conv_clock_invert <=
                {clk_inv[4:1], !clk_inv[0], clk_inv[0]}; // RULE5
            rail_discharge_enable <=
                converter_clock_polarity[pscb_pkg::BIT_DISCHARGE]; // RULE7
        end
    end

    // ****************************************
    // Host interface modes
    // ****************************************
    // Mode levels only; the host interface itself lives outside this bank
    always_ff @(posedge clk) begin
        if (!rstn) begin
            continuous_highspeed_enable <= 1'b0;
            fast_plus_timing_enable <= 1'b0;
        end else begin
            continuous_highspeed_enable <= hs_cont; // RULE10
            fast_plus_timing_enable <= fast_plus; // RULE11
        end
    end

    // ****************************************
    // System enable reload on second OTP read
    // ****************************************
    // No register write reaches it; only the reload strobe changes it
    always_ff @(posedge clk) begin
        if (!rstn) begin
            system_enable <= 1'b0;
        end else if (otp_second_read && !sysen_keep) begin
            system_enable <= otp_system_enable; // RULE12
        end
    end

    // ****************************************
    // Power-up selection of rails and switches
    // ****************************************
    // Autostart can only add a rail, never drop one its own setting enables
    logic [5:0] conv_auto;
    logic [1:0] switch_auto;

    assign conv_auto = rail_powerup_auto_enable[pscb_pkg::CONV_AUTO_LSB +: 6];
    assign switch_auto = rail_powerup_auto_enable[pscb_pkg::SW_AUTO_LSB +: 2];

    always_ff @(posedge clk) begin
        if (!rstn) begin
            conv_powerup_enable <= 6'h00;
            switch_powerup_enable <= 2'h0;
        end else begin
            conv_powerup_enable <= conv_own_enable | conv_auto; // RULE14
            switch_powerup_enable <= switch_own_enable | switch_auto; // RULE15
        end
    end
endmodule
`default_nettype wire

// *** sim/pscb_config_bank_sva.sv ***
`default_nettype none
module pscb_config_bank_sva #(
    parameter int ADDR_W = 9
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] rd_data,
    input wire logic seq_reset_request,
    input wire logic otp_second_read,
    input wire logic interrupt_request_output,
    input wire logic interrupt_request_oe,
    input wire logic reset_output_pin,
    input wire logic reset_output_oe,
    input wire logic feedback_two_out,
    input wire logic feedback_two_oe,
    input wire logic [8:0] fault_hysteresis_mv,
    input wire logic [2:0] fault_hysteresis_code,
    input wire logic [3:0] fault_threshold_code,
    input wire logic [5:0] conv_clock_invert,
    input wire logic system_enable
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // ****************************************
    // Storable bits per address, zero when unmapped
    // ****************************************
    function automatic logic [7:0] mask_of(input logic [ADDR_W-1:0] a);
        case (a)
            pscb_pkg::OFS_OUTPUT_PIN: return pscb_pkg::MASK_OUTPUT_PIN;
            pscb_pkg::OFS_FAULT: return pscb_pkg::MASK_FAULT;
            pscb_pkg::OFS_CLK_POL: return pscb_pkg::MASK_CLK_POL;
            pscb_pkg::OFS_HOST_IRQ: return pscb_pkg::MASK_HOST_IRQ;
            pscb_pkg::OFS_AUTOSTART: return pscb_pkg::MASK_AUTOSTART;
            default: return 8'h00;
        endcase
    endfunction
    rd_reserved_a: assert property ($past(rstn) |-> (rd_data &
        ~($past(rd_en) ? mask_of($past(addr)) : 8'h00)) == 8'h00)
        else $error("read data outside storable bits");
    fault_write_a: assert property ($past(rstn) &&
        $past(rstn, 2) && $past(wr_en, 2) &&
        $past(addr, 2) == pscb_pkg::OFS_FAULT &&
        !($past(wr_en) && $past(addr) == pscb_pkg::OFS_FAULT) |->
        {1'b0, fault_hysteresis_code, fault_threshold_code} ==
        ($past(wr_data, 2) & 8'h7f))
        else $error("fault codes differ from written value");
    hyst_scale_a: assert property (fault_hysteresis_mv ==
        9'h064 + 9'(fault_hysteresis_code) * 9'h032)
        else $error("hysteresis millivolts wrong");
    core_two_a: assert property (conv_clock_invert[1] ==
        !conv_clock_invert[0])
        else $error("core two clock not opposite core one");
    reset_req_a: assert property ($past(rstn) &&
        $past(seq_reset_request) |-> !reset_output_pin)
        else $error("reset output not asserted");
    release_high_a: assert property ((interrupt_request_oe ||
        interrupt_request_output) && (reset_output_oe || reset_output_pin))
        else $error("released pin not at high level");
    fb2_release_a: assert property (!feedback_two_oe |->
        feedback_two_out)
        else $error("feedback two released while low");
    sysen_hold_a: assert property ($past(rstn) &&
        !$past(otp_second_read) |-> $stable(system_enable))
        else $error("system enable changed without reload");
endmodule
bind pscb_config_bank pscb_config_bank_sva #(.ADDR_W(ADDR_W)) chk_i (
    .clk(clk), .rstn(rstn), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .seq_reset_request(seq_reset_request),
    .otp_second_read(otp_second_read),
    .interrupt_request_output(interrupt_request_output),
    .interrupt_request_oe(interrupt_request_oe),
    .reset_output_pin(reset_output_pin), .reset_output_oe(reset_output_oe),
    .feedback_two_out(feedback_two_out), .feedback_two_oe(feedback_two_oe),
    .fault_hysteresis_mv(fault_hysteresis_mv),
    .fault_hysteresis_code(fault_hysteresis_code),
    .fault_threshold_code(fault_threshold_code),
    .conv_clock_invert(conv_clock_invert), .system_enable(system_enable));
`default_nettype wire

// *** sim/pscb_config_bank_bench.sv ***
`default_nettype none
module pscb_config_bank_bench;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [8:0] a;
        logic [7:0] d;
        logic [7:0] r;
    } pscb_row_t;
    // Reserved bits are written as ones so that leaks show
    localparam pscb_row_t ROWS [0:6] = '{'{9'h106, 8'hff, 8'h0c},
        '{9'h107, 8'hff, 8'h7f}, '{9'h108, 8'hef, 8'hec},
        '{9'h109, 8'hdf, 8'hde}, '{9'h10a, 8'hff, 8'hff},
        '{9'h10b, 8'hff, 8'h00}, '{9'h106, 8'hf3, 8'h00}};
    logic clk = 0, rstn = 0, wr_en = 0, rd_en = 0, irq = 0, act = 1;
    logic seq = 0, fb2 = 0, pg = 0, fb3 = 0, otp = 0, otpv = 0;
    logic [8:0] addr = 9'h000;
    logic [7:0] wr_data = 8'h00, rd_data, d, q;
    logic [5:0] own = 6'h00, cinv, cpu;
    logic [1:0] swo = 2'h0, spu;
    logic irq_o, irq_oe, rst_o, rst_oe, fb2_o, fb2_oe, fb3_o, lv, l2;
    logic dis, hs, fp, sen;
    logic [8:0] hmv;
    logic [11:0] tmv;
    logic [2:0] hc;
    logic [3:0] tc;
    int error_cnt = 0, n_checks = 0;
    always #50 clk = ~clk;
    pscb_config_bank dut (.clk(clk), .rstn(rstn), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .irq_pending(irq), .in_active_mode(act), .seq_reset_request(seq),
        .fb2_event(fb2), .fb2_is_power_good(pg), .fb3_event(fb3),
        .otp_second_read(otp), .otp_system_enable(otpv),
        .conv_own_enable(own), .switch_own_enable(swo),
        .interrupt_request_output(irq_o), .interrupt_request_oe(irq_oe),
        .reset_output_pin(rst_o), .reset_output_oe(rst_oe),
        .feedback_two_out(fb2_o), .feedback_two_oe(fb2_oe),
        .feedback_three_out(fb3_o), .fault_hysteresis_mv(hmv),
        .fault_threshold_mv(tmv), .fault_hysteresis_code(hc),
        .fault_threshold_code(tc), .conv_clock_invert(cinv),
        .rail_discharge_enable(dis), .continuous_highspeed_enable(hs),
        .fast_plus_timing_enable(fp), .system_enable(sen),
        .conv_powerup_enable(cpu), .switch_powerup_enable(spu));
    // ****************************************
    // Bus cycles and comparison
    // ****************************************
    task automatic wr(input logic [8:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wr_data <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [8:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 v = rd_data;
    endtask
    // Pins lag a register write by two edges; three leaves margin
    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic pulse(input logic v);
        @(posedge clk);
        otp <= 1'b1;
        otpv <= v;
        @(posedge clk);
        otp <= 1'b0;
        settle;
    endtask
    task automatic chk(input string nm, input logic [11:0] e,
        input logic [11:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // The tests need under a thousand cycles; this limit leaves wide margin
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        tally_and_finish;
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        #1 chk("reset_pins", 12'h821, {irq_o, rst_o, cinv, 4'h1});
        chk("reset_mv", 12'h9c4, tmv);
        chk("reset_hmv", 12'h064, 12'(hmv));
        for (int i = 0; i < 5; i++) begin
            rd(9'(9'h106 + i), q);
            chk("reset_val", 12'h000, 12'(q));
        end
        foreach (ROWS[i]) begin
            wr(ROWS[i].a, ROWS[i].d);
            rd(ROWS[i].a, q);
            chk("readback", 12'(ROWS[i].r), 12'(q));
        end
        for (int i = 0; i < 16; i++) begin
            wr(9'h107, 8'(i * 17));
            settle;
            chk("hyst_mv", 12'(100 + 50 * (i % 8)), 12'(hmv));
            chk("thr_mv", 12'(2500 + 50 * i), tmv);
            chk("codes", 12'(i * 17 & 8'h7f), 12'({hc, tc}));
        end
        for (int i = 0; i < 7; i++) begin
            d = 8'(16'h0004 << i);
            d[4] = !d[5];
            wr(9'h108, d);
            settle;
            chk("clk_inv", 12'({d[7:4], !d[3], d[3]}), 12'(cinv));
            chk("discharge", 12'(d[2]), 12'(dis));
        end
        for (int i = 0; i < 8; i++) begin
            wr(9'h106, {4'hf, i[1], i[0], 2'h3});
            @(posedge clk);
            irq <= i[2];
            settle;
            lv = i[1] ? i[2] : !i[2];
            chk("irq_pin", 12'(lv), 12'(irq_o));
            chk("irq_oe", 12'(i[0] ? !lv : 1'b1), 12'(irq_oe));
            chk("rst_oe", 12'(!i[0]), 12'(rst_oe));
        end
        for (int i = 0; i < 4; i++) begin
            d = 8'h04 << i;
            wr(9'h109, d);
            settle;
            chk("hs_fp", 12'({d[4], d[3]}), 12'({hs, fp}));
            chk("rst_pin", 12'(!d[5]), 12'(rst_o));
        end
        wr(9'h109, 8'h00);
        @(posedge clk);
        seq <= 1'b1;
        settle;
        chk("rst_seq", 12'h000, 12'(rst_o));
        @(posedge clk);
        seq <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            wr(9'h109, {i[1], i[0], 6'h00});
            @(posedge clk);
            fb2 <= i[2];
            fb3 <= i[2];
            pg <= i[3];
            settle;
            l2 = i[0] ? i[2] : !i[2];
            chk("fb3", 12'(i[1] ? i[2] : !i[2]), 12'(fb3_o));
            lv = !(i[3] && i[0] && l2);
            chk("fb2", 12'({l2, lv}), 12'({fb2_o, fb2_oe}));
        end
        wr(9'h106, 8'h00);
        wr(9'h109, 8'h02);
        @(posedge clk);
        act <= 1'b0;
        irq <= 1'b1;
        settle;
        chk("irq_defer", 12'h001, 12'(irq_o));
        @(posedge clk);
        act <= 1'b1;
        settle;
        chk("irq_active", 12'h000, 12'(irq_o));
        wr(9'h109, 8'h00);
        @(posedge clk);
        act <= 1'b0;
        settle;
        chk("irq_now", 12'h000, 12'(irq_o));
        pulse(1'b1);
        chk("sysen_load", 12'h001, 12'(sen));
        wr(9'h109, 8'h04);
        pulse(1'b0);
        chk("sysen_keep", 12'h001, 12'(sen));
        wr(9'h109, 8'h00);
        pulse(1'b0);
        chk("sysen_clear", 12'h000, 12'(sen));
        @(posedge clk);
        own <= 6'h21;
        swo <= 2'h1;
        wr(9'h10a, 8'h86);
        settle;
        chk("autostart", 12'h0e7, 12'({spu, cpu}));
        wr(9'h10a, 8'h00);
        settle;
        chk("own_cfg", 12'h061, 12'({spu, cpu}));
        wr(9'h10a, 8'hff);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        rd(9'h10a, q);
        chk("mid_reset", 12'h000, 12'(q));
        tally_and_finish;
    end
endmodule
`default_nettype wire
